// file: csc_pkg.sv
// constants shared by the contact input scanner
// Notes on behaviour
// RQ1: 48 inputs, two boards of 24
// RQ2: sample all inputs once per control frame
// RQ3: sample event inputs every 1 ms
// RQ4: log every open and close, 1 ms stamp
// RQ5: chatter and 6 ms pulses never lost; one slot per input, a newer change overwrites it and sets overrun
// RQ6: 4 ms stability filter on each input
// RQ7: software delay 0, 10, 20 or 50 ms
// RQ8: invert makes open contact read true
// RQ9: per input event recorder enable bit
// RQ10: global switch for all limit checking
// RQ11: unconnected board port inputs not processed
// RQ12: any unhealthy input raises composite alarm
// RQ13: latched diagnostic clears only once healthy
// RQ14: excitation below 40 percent latches alarm
// RQ15: flag excitation loss, test failure, unplugged cable
// RQ16: green flashing, red fail, orange on alarm
// RQ17: read identification chip of each board
// RQ18: partner votes results of three racks
// RQ19: partner vote is two of three
// RQ20: software delay needs unbroken stable time
package csc_pkg;
    localparam int NUM_CH = 48;
    localparam int CH_PER_BOARD = 24;
    localparam int NUM_BOARDS = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] HW_FILT_MS = 3'h4;
    localparam logic [5:0] SW_DLY_0 = 6'h00;
    localparam logic [5:0] SW_DLY_10 = 6'h0a;
    localparam logic [5:0] SW_DLY_20 = 6'h14;
    localparam logic [5:0] SW_DLY_50 = 6'h32;
    localparam logic [3:0] TEST_SETTLE_MS = 4'h8;
    localparam logic [8:0] FLASH_MS = 9'h1f4;
    localparam logic [15:0] EXC_LOW_PCT = 16'h0028;
    localparam logic [15:0] PCT_FULL = 16'h0064;
    localparam logic [7:0] EXC_NOM_RST = 8'hc8;
    localparam logic [5:0] ID_HALF_CYC = 6'h32;
    localparam logic [4:0] ID_LAST_BIT = 5'h1f;
    // id word layout
    localparam int ID_SERIAL_LSB = 0;
    localparam int ID_TYPE_LSB = 16;
    localparam int ID_REV_LSB = 24;
    localparam int ID_LOC_LSB = 30;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_INV0 = 8'h04;
    localparam logic [7:0] A_INV1 = 8'h08;
    localparam logic [7:0] A_EVEN0 = 8'h0c;
    localparam logic [7:0] A_EVEN1 = 8'h10;
    localparam logic [7:0] A_LATCH0 = 8'h14;
    localparam logic [7:0] A_LATCH1 = 8'h18;
    localparam logic [7:0] A_FILT0 = 8'h1c;
    localparam logic [7:0] A_FILT1 = 8'h20;
    localparam logic [7:0] A_FILT2 = 8'h24;
    localparam logic [7:0] A_FILT3 = 8'h28;
    localparam logic [7:0] A_STATE0 = 8'h30;
    localparam logic [7:0] A_STATE1 = 8'h34;
    localparam logic [7:0] A_DIAG0 = 8'h38;
    localparam logic [7:0] A_DIAG1 = 8'h3c;
    localparam logic [7:0] A_STATUS = 8'h40;
    localparam logic [7:0] A_ID0 = 8'h44;
    localparam logic [7:0] A_ID1 = 8'h48;
    localparam logic [7:0] A_EXCNOM = 8'h4c;
    // control bits
    localparam int C_LIMIT = 0;
    localparam int C_CONN0 = 1;
    localparam int C_CONN1 = 2;
    localparam int C_TEST = 3;
    localparam int C_FAIL = 4;
    localparam int C_DRST = 5;
    localparam int C_IDRD = 6;
    localparam logic [4:0] CTRL_RST = 5'h07;
    // id reader states
    typedef enum logic [2:0] {
        ID_IDLE = 3'b001,
        ID_LOW = 3'b010,
        ID_HIGH = 3'b100
    } csc_id_e;
    // software delay in ms from the 2-bit choice
    function automatic logic [5:0] sw_delay(input logic [1:0] sel);
        case (sel)
            2'h1: sw_delay = SW_DLY_10;
            2'h2: sw_delay = SW_DLY_20;
            2'h3: sw_delay = SW_DLY_50;
            default: sw_delay = SW_DLY_0;
        endcase
    endfunction
endpackage

// file: csc_scanner.sv
// contact input scanner: filters, frame sampling, event capture, diagnostics
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module csc_scanner
    import csc_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // contact side pins
    input wire logic [NUM_CH-1:0] contact_raw_i,
    input wire logic [NUM_BOARDS-1:0] cable_present_i,
    input wire logic [15:0] exc_level_i,
    output logic [NUM_BOARDS-1:0] test_drive_o,
    output logic [NUM_BOARDS-1:0] id_clk_o,
    input wire logic [NUM_BOARDS-1:0] id_data_i,
    // system timing and commands
    input wire logic frame_tick_i,
    input wire logic diag_reset_cmd_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // frame samples
    output logic [NUM_CH-1:0] frame_data_o,
    output logic frame_valid_o,
    // event recorder stream
    output logic event_valid_o,
    input wire logic event_ready_i,
    output logic [5:0] event_chan_o,
    output logic event_state_o,
    output logic [15:0] event_stamp_o,
    // alarm and indicators
    output logic board_diag_alarm_o,
    output logic led_run_o,
    output logic led_fail_o,
    output logic led_diag_o
);
    logic [NUM_CH-1:0] raw_s1_q, raw_s2_q;
    logic [NUM_BOARDS-1:0] cab_s1_q, cab_s2_q, id_s1_q, id_s2_q;
    logic [16:0] ms_cnt_q;
    logic ms_tick_q;
    logic [15:0] ms_time_q;
    logic [4:0] ctrl_q;
    logic [NUM_CH-1:0] inv_q, even_q, latch_en_q;
    logic [2*NUM_CH-1:0] filt_q;
    logic [7:0] exc_nom_q;
    logic drst_q, id_req_q, overrun_q;
    logic [NUM_BOARDS-1:0] conn, exc_low, exc_alarm_q;
    logic [NUM_CH-1:0] hw_q, sw_q, rep, ev_cur, ev_prev_q, cond, diag_q, diag_vis;
    logic [NUM_CH-1:0] ev_pend_q, ev_state_q, ev_set, ev_clr;
    logic [15:0] ev_stamp_q [NUM_CH];
    logic [3:0] settle_q;
    logic settled;
    logic [5:0] ev_idx;
    logic [31:0] rdata_q;
    logic [NUM_CH-1:0] frame_q;
    logic frame_v_q;
    logic [8:0] flash_cnt_q;
    logic flash_q;
    csc_id_e id_st_q;
    logic id_port_q;
    logic [4:0] id_bit_q;
    logic [5:0] id_div_q;
    logic [31:0] id_shift_q;
    logic [31:0] id_word_q [NUM_BOARDS];

    // contact, cable and id pins cross in through two flops; the excitation level is used as it comes
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            raw_s1_q <= '0;
            raw_s2_q <= '0;
            // start as plugged, so reset alone latches no cable fault
            cab_s1_q <= '1;
            cab_s2_q <= '1;
            id_s1_q <= '0;
            id_s2_q <= '0;
        end
        else
        begin
            raw_s1_q <= contact_raw_i;
            raw_s2_q <= raw_s1_q;
            cab_s1_q <= cable_present_i;
            cab_s2_q <= cab_s1_q;
            id_s1_q <= id_data_i;
            id_s2_q <= id_s1_q;
        end

    // millisecond tick and timestamp, the 1 kHz scan rate
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            ms_cnt_q <= '0;
            ms_tick_q <= 1'b0;
            ms_time_q <= '0;
        end
        else
        begin
            ms_tick_q <= (ms_cnt_q == 17'(MS_CYCLES_P - 1)); // see RQ3
            ms_cnt_q <= (ms_cnt_q == 17'(MS_CYCLES_P - 1)) ? '0 : ms_cnt_q + 17'h1;
            if (ms_tick_q)
                ms_time_q <= ms_time_q + 16'h1; // see RQ4
        end

    assign conn = {ctrl_q[C_CONN1], ctrl_q[C_CONN0]}; // see RQ11

    // per board excitation check, live compare of ratio to nominal
    for (genvar b = 0; b < NUM_BOARDS; b++)
    begin : g_brd
        logic [15:0] lvl;
        assign lvl = {8'h00, exc_level_i[b*8 +: 8]};
        assign exc_low[b] = ctrl_q[C_LIMIT] & conn[b] & // see RQ10
            (lvl * PCT_FULL < {8'h00, exc_nom_q} * EXC_LOW_PCT); // see RQ14
        always_ff @(posedge sys_clk_i or negedge rstn_i)
            if (!rstn_i)
                exc_alarm_q[b] <= 1'b0;
            else if (exc_low[b])
                exc_alarm_q[b] <= 1'b1; // see RQ14
            else if (drst_q)
                exc_alarm_q[b] <= 1'b0; // see RQ13
    end

    // test mode settle time, filter must see the forced closure first
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
            settle_q <= '0;
        else if (!ctrl_q[C_TEST])
            settle_q <= '0;
        else if (ms_tick_q && !settled)
            settle_q <= settle_q + 4'h1;
    assign settled = (settle_q == TEST_SETTLE_MS);
    assign test_drive_o = {NUM_BOARDS{ctrl_q[C_TEST]}} & conn;

    // per channel filters, event capture and diagnostics
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch // see RQ1
        localparam int B = g / CH_PER_BOARD;
        logic [2:0] hw_cnt_q;
        logic [5:0] sw_cnt_q, dly;
        assign dly = sw_delay(filt_q[2*g +: 2]); // see RQ7
        // hardware style stability filter
        always_ff @(posedge sys_clk_i or negedge rstn_i)
            if (!rstn_i)
            begin
                hw_cnt_q <= '0;
                hw_q[g] <= 1'b0;
            end
            else if (raw_s2_q[g] == hw_q[g])
                hw_cnt_q <= '0;
            else if (ms_tick_q)
            begin
                if (hw_cnt_q == HW_FILT_MS - 3'h1)
                begin
                    hw_q[g] <= raw_s2_q[g]; // see RQ6
                    hw_cnt_q <= '0;
                end
                else
                    hw_cnt_q <= hw_cnt_q + 3'h1;
            end
        // software delay restarts on any bounce back
        always_ff @(posedge sys_clk_i or negedge rstn_i)
            if (!rstn_i)
            begin
                sw_cnt_q <= '0;
                sw_q[g] <= 1'b0;
            end
            else if (hw_q[g] == sw_q[g])
                sw_cnt_q <= '0; // see RQ20
            else if (dly == SW_DLY_0)
                sw_q[g] <= hw_q[g]; // see RQ20
            else if (ms_tick_q)
            begin
                if (sw_cnt_q == dly - 6'h1)
                begin
                    sw_q[g] <= hw_q[g]; // see RQ7
                    sw_cnt_q <= '0;
                end
                else
                    sw_cnt_q <= sw_cnt_q + 6'h1;
            end
        assign rep[g] = conn[B] & (sw_q[g] ^ inv_q[g]); // see RQ8
        assign ev_cur[g] = conn[B] & (hw_q[g] ^ inv_q[g]);
        assign ev_set[g] = ms_tick_q & even_q[g] & conn[B] & (ev_cur[g] != ev_prev_q[g]); // see RQ9
        assign ev_clr[g] = event_valid_o & event_ready_i & (ev_idx == 6'(g));
        // one slot per channel, new change wins over a same cycle drain
        always_ff @(posedge sys_clk_i or negedge rstn_i)
            if (!rstn_i)
            begin
                ev_prev_q[g] <= 1'b0;
                ev_pend_q[g] <= 1'b0;
                ev_state_q[g] <= 1'b0;
                ev_stamp_q[g] <= '0;
            end
            else
            begin
                if (ms_tick_q)
                    ev_prev_q[g] <= ev_cur[g]; // see RQ3
                if (ev_set[g])
                begin
                    ev_pend_q[g] <= 1'b1; // see RQ4
                    ev_state_q[g] <= ev_cur[g];
                    ev_stamp_q[g] <= ms_time_q;
                end
                else if (ev_clr[g])
                    ev_pend_q[g] <= 1'b0;
            end
        assign cond[g] = conn[B] & (!cab_s2_q[B] | exc_low[B] | (settled & !hw_q[g])); // see RQ15
        always_ff @(posedge sys_clk_i or negedge rstn_i)
            if (!rstn_i)
                diag_q[g] <= 1'b0;
            else if (cond[g])
                diag_q[g] <= 1'b1;
            else if (drst_q)
                diag_q[g] <= 1'b0; // see RQ13
        assign diag_vis[g] = latch_en_q[g] ? (diag_q[g] | cond[g]) : cond[g]; // see RQ12
    end

    // overrun: a change landed while the slot still held one
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
            overrun_q <= 1'b0;
        else if (|(ev_set & ev_pend_q & ~ev_clr))
            overrun_q <= 1'b1; // see RQ5
        else if (drst_q)
            overrun_q <= 1'b0;

    // lowest pending channel goes out first
    always_comb
    begin
        ev_idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
            if (ev_pend_q[i])
                ev_idx = 6'(i);
    end
    assign event_valid_o = |ev_pend_q;
    assign event_chan_o = ev_idx;
    assign event_state_o = ev_state_q[ev_idx];
    assign event_stamp_o = ev_stamp_q[ev_idx];

    // frame snapshot for control use
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            frame_q <= '0;
            frame_v_q <= 1'b0;
        end
        else
        begin
            frame_v_q <= frame_tick_i;
            if (frame_tick_i)
                frame_q <= rep; // see RQ2
        end
    assign frame_data_o = frame_q;
    assign frame_valid_o = frame_v_q;

    // indicators; green stops flashing while fail is shown
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end
        else if (ms_tick_q)
        begin
            flash_cnt_q <= (flash_cnt_q == FLASH_MS - 9'h1) ? '0 : flash_cnt_q + 9'h1;
            if (flash_cnt_q == FLASH_MS - 9'h1)
                flash_q <= ~flash_q;
        end
    assign board_diag_alarm_o = (|diag_vis) | (|exc_alarm_q); // see RQ12
    assign led_run_o = flash_q & ~ctrl_q[C_FAIL]; // see RQ16
    assign led_fail_o = ctrl_q[C_FAIL];
    assign led_diag_o = board_diag_alarm_o;

    // id chip reader, both ports in turn, msb first
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            id_st_q <= ID_IDLE;
            id_port_q <= 1'b0;
            id_bit_q <= '0;
            id_div_q <= '0;
            id_shift_q <= '0;
            id_word_q[0] <= '0;
            id_word_q[1] <= '0;
        end
        else
            case (id_st_q)
                ID_IDLE:
                    if (id_req_q)
                    begin
                        id_st_q <= ID_LOW;
                        id_port_q <= 1'b0;
                        id_bit_q <= '0;
                        id_div_q <= '0;
                    end
                ID_LOW:
                    if (id_div_q == ID_HALF_CYC - 6'h1)
                    begin
                        id_div_q <= '0;
                        id_st_q <= ID_HIGH;
                        id_shift_q <= {id_shift_q[30:0], id_s2_q[id_port_q]}; // see RQ17
                    end
                    else
                        id_div_q <= id_div_q + 6'h1;
                ID_HIGH:
                    if (id_div_q != ID_HALF_CYC - 6'h1)
                        id_div_q <= id_div_q + 6'h1;
                    else
                    begin
                        id_div_q <= '0;
                        id_bit_q <= id_bit_q + 5'h1;
                        id_st_q <= ID_LOW;
                        if (id_bit_q == ID_LAST_BIT)
                        begin
                            id_word_q[id_port_q] <= id_shift_q;
                            id_port_q <= 1'b1;
                            if (id_port_q)
                                id_st_q <= ID_IDLE;
                        end
                    end
                default:
                    id_st_q <= ID_IDLE;
            endcase
    assign id_clk_o = {id_port_q, ~id_port_q} & {NUM_BOARDS{id_st_q == ID_HIGH}};

    // register writes and command pulses
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            ctrl_q <= CTRL_RST;
            inv_q <= '0;
            even_q <= '0;
            latch_en_q <= '0;
            filt_q <= '0;
            exc_nom_q <= EXC_NOM_RST;
            drst_q <= 1'b0;
            id_req_q <= 1'b1;
        end
        else
        begin
            drst_q <= diag_reset_cmd_i | (reg_wr_i & (reg_addr_i == A_CTRL) & reg_wdata_i[C_DRST]);
            if (id_st_q == ID_IDLE)
                id_req_q <= 1'b0;
            if (reg_wr_i)
                case (reg_addr_i)
                    A_CTRL:
                    begin
                        ctrl_q <= reg_wdata_i[4:0];
                        if (reg_wdata_i[C_IDRD])
                            id_req_q <= 1'b1;
                    end
                    A_INV0: inv_q[23:0] <= reg_wdata_i[23:0];
                    A_INV1: inv_q[47:24] <= reg_wdata_i[23:0];
                    A_EVEN0: even_q[23:0] <= reg_wdata_i[23:0];
                    A_EVEN1: even_q[47:24] <= reg_wdata_i[23:0];
                    A_LATCH0: latch_en_q[23:0] <= reg_wdata_i[23:0];
                    A_LATCH1: latch_en_q[47:24] <= reg_wdata_i[23:0];
                    A_FILT0: filt_q[23:0] <= reg_wdata_i[23:0];
                    A_FILT1: filt_q[47:24] <= reg_wdata_i[23:0];
                    A_FILT2: filt_q[71:48] <= reg_wdata_i[23:0];
                    A_FILT3: filt_q[95:72] <= reg_wdata_i[23:0];
                    A_EXCNOM: exc_nom_q <= reg_wdata_i[7:0];
                    default: ;
                endcase
        end

    // register reads, unmapped words read zero
    always_ff @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i)
            rdata_q <= '0;
        else if (reg_rd_i)
            case (reg_addr_i)
                A_CTRL: rdata_q <= {27'h0, ctrl_q};
                A_INV0: rdata_q <= {8'h0, inv_q[23:0]};
                A_INV1: rdata_q <= {8'h0, inv_q[47:24]};
                A_EVEN0: rdata_q <= {8'h0, even_q[23:0]};
                A_EVEN1: rdata_q <= {8'h0, even_q[47:24]};
                A_LATCH0: rdata_q <= {8'h0, latch_en_q[23:0]};
                A_LATCH1: rdata_q <= {8'h0, latch_en_q[47:24]};
                A_FILT0: rdata_q <= {8'h0, filt_q[23:0]};
                A_FILT1: rdata_q <= {8'h0, filt_q[47:24]};
                A_FILT2: rdata_q <= {8'h0, filt_q[71:48]};
                A_FILT3: rdata_q <= {8'h0, filt_q[95:72]};
                A_STATE0: rdata_q <= {8'h0, rep[23:0]};
                A_STATE1: rdata_q <= {8'h0, rep[47:24]};
                A_DIAG0: rdata_q <= {8'h0, diag_vis[23:0]};
                A_DIAG1: rdata_q <= {8'h0, diag_vis[47:24]};
                A_STATUS: rdata_q <= {24'h0, (id_st_q != ID_IDLE), overrun_q, cab_s2_q, exc_low, exc_alarm_q};
                A_ID0: rdata_q <= id_word_q[0];
                A_ID1: rdata_q <= id_word_q[1];
                A_EXCNOM: rdata_q <= {24'h0, exc_nom_q};
                default: rdata_q <= '0;
            endcase
        else
            rdata_q <= '0;
    assign reg_rdata_o = rdata_q;

    // checks on the guarded behaviour
    sequence ev_change_s;
        ms_tick_q && even_q[3] && conn[0] && (ev_cur[3] != ev_prev_q[3]);
    endsequence
    sequence ev_logged_s;
        ev_pend_q[3] && ev_state_q[3] == $past(ev_cur[3]) && ev_stamp_q[3] == $past(ms_time_q);
    endsequence
    frame_sample_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ2
        frame_tick_i |=> frame_valid_o && frame_data_o == $past(rep))
        else $error("frame sample mismatch");
    ms_period_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ3
        ms_tick_q |=> !ms_tick_q && ms_cnt_q == 17'h1)
        else $error("ms tick not periodic");
    event_log_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ4
        ev_change_s |=> ev_logged_s)
        else $error("event not logged");
    hw_filter_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ6
        $changed(hw_q[0]) |-> $past(ms_tick_q) && $past(g_ch[0].hw_cnt_q) == HW_FILT_MS - 3'h1)
        else $error("filter changed early");
    sw_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ20
        (filt_q[1:0] == 2'h0 && hw_q[0] != sw_q[0]) |=> sw_q[0] == $past(hw_q[0]))
        else $error("zero delay did not pass");
    diag_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ13
        cond[0] |=> diag_q[0])
        else $error("unhealthy diag cleared");
    alarm_out_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ12
        (|cond) |-> board_diag_alarm_o && led_diag_o)
        else $error("composite alarm missing");
    exc_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ14
        exc_low[0] ##1 !exc_low[0] && !drst_q |=> exc_alarm_q[0])
        else $error("excitation alarm not latched");
    unconn_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ11
        !ctrl_q[C_CONN0] |-> rep[23:0] == 24'h0 && cond[23:0] == 24'h0)
        else $error("unconnected port processed");
    invert_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ8
        conn[0] |-> rep[0] == (sw_q[0] ^ inv_q[0]))
        else $error("inversion wrong");
endmodule

// file: csc_comm_model.sv
// backplane board model: event consumer and rack vote
`timescale 1ns/10ps
module csc_comm_model
    import csc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // rack results
    input wire logic [NUM_CH-1:0] rack_r_i,
    input wire logic [NUM_CH-1:0] rack_s_i,
    input wire logic [NUM_CH-1:0] rack_t_i,
    output logic [NUM_CH-1:0] voted_o,
    // event stream
    input wire logic stall_i,
    input wire logic event_valid_i,
    input wire logic [5:0] event_chan_i,
    input wire logic event_state_i,
    output logic event_ready_o,
    output logic [7:0] event_cnt_o,
    output logic last_state_o
);
    // bitwise majority, one bad rack cannot flip a point
    assign voted_o = (rack_r_i & rack_s_i) | (rack_s_i & rack_t_i) | (rack_r_i & rack_t_i);
    // consumer takes no events while stalled
    assign event_ready_o = !stall_i;
    // log every accepted event
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            event_cnt_o <= 8'h00;
            last_state_o <= 1'b0;
        end
        else if (event_valid_i && event_ready_o)
        begin
            event_cnt_o <= event_cnt_o + 8'h01;
            last_state_o <= event_state_i;
        end
    end
endmodule

// file: tb.sv
// testbench for the contact input scanner
`timescale 1ns/10ps
module tb
    import csc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [NUM_CH-1:0] raw = '0;
    logic [15:0] exc = 16'hc8c8;
    logic tick = 1'b0;
    logic drst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic stall = 1'b0;
    logic [1:0] cab = 2'b11;
    logic [1:0] tdrv;
    logic lrun, lfail;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rv;
    logic [NUM_CH-1:0] fdata, voted;
    logic fvalid, evalid, ready, estate, alarm, ldiag, lstate;
    logic [5:0] echan;
    logic [7:0] ecnt;
    int miscompares = 0;
    int checks_done = 0;
    // free running clock
    always #5 sys_clk = ~sys_clk;
    csc_scanner #(.MS_CYCLES_P(20)) i_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .contact_raw_i(raw),
        .cable_present_i(cab), .exc_level_i(exc), .test_drive_o(tdrv), .id_clk_o(), .id_data_i(2'b01),
        .frame_tick_i(tick), .diag_reset_cmd_i(drst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .frame_data_o(fdata), .frame_valid_o(fvalid),
        .event_valid_o(evalid), .event_ready_i(ready), .event_chan_o(echan), .event_state_o(estate),
        .event_stamp_o(), .board_diag_alarm_o(alarm), .led_run_o(lrun), .led_fail_o(lfail), .led_diag_o(ldiag));
    // third rack inverted so only a real majority passes
    csc_comm_model i_comm (.sys_clk_i(sys_clk), .rstn_i(rstn), .rack_r_i(fdata), .rack_s_i(fdata),
        .rack_t_i(~fdata), .voted_o(voted), .stall_i(stall), .event_valid_i(evalid),
        .event_chan_i(echan), .event_state_i(estate), .event_ready_o(ready), .event_cnt_o(ecnt),
        .last_state_o(lstate));
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic ms(input int n);
        repeat (n * 20) @(posedge sys_clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // read data only stands in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic frame(input logic [47:0] e);
        @(posedge sys_clk);
        tick <= 1'b1;
        @(posedge sys_clk);
        tick <= 1'b0;
        #1;
        chk("fvalid", 48'h1, {47'h0, fvalid});
        chk("fdata", e, fdata);
        chk("voted", e, voted);
    endtask
    task automatic dreset();
        @(posedge sys_clk);
        drst <= 1'b1;
        @(posedge sys_clk);
        drst <= 1'b0;
        ms(1);
        #1;
    endtask
    task automatic t_regs();
        rreg(A_CTRL);
        chk("ctrl", 48'h7, {16'h0, rv});
        rreg(8'h2c);
        chk("unmapped", 48'h0, {16'h0, rv});
    endtask
    task automatic t_frame();
        wreg(A_INV0, 32'h2);
        raw[0] <= 1'b1;
        raw[30] <= 1'b1;
        ms(2);
        frame(48'h2);
        ms(4);
        frame(48'h4000_0003);
    endtask
    // ch0 on a 10 ms software delay
    task automatic t_filter();
        wreg(A_FILT0, 32'h1);
        raw[0] <= 1'b0;
        ms(8);
        frame(48'h4000_0003);
        ms(8);
        frame(48'h4000_0002);
        wreg(A_CTRL, 32'h5);
        ms(1);
        frame(48'h4000_0000);
        wreg(A_CTRL, 32'h7);
        ms(1);
    endtask
    // 6 ms pulse on ch3, consumer stalled over the rise
    task automatic t_event();
        wreg(A_EVEN0, 32'h8);
        stall <= 1'b1;
        raw[3] <= 1'b1;
        ms(6);
        #1;
        chk("ev_valid", 48'h1, {47'h0, evalid});
        chk("ev_chan", 48'h3, {42'h0, echan});
        chk("ev_state", 48'h1, {47'h0, estate});
        @(posedge sys_clk);
        stall <= 1'b0;
        raw[3] <= 1'b0;
        ms(8);
        chk("ev_count", 48'h2, {40'h0, ecnt});
        chk("ev_last", 48'h0, {47'h0, lstate});
    endtask
    // board0 at 64 of 200 nominal
    task automatic t_exc();
        wreg(A_CTRL, 32'h6);
        exc <= 16'hc840;
        ms(2);
        chk("alarm_off", 48'h0, {47'h0, alarm});
        wreg(A_CTRL, 32'h7);
        ms(2);
        rreg(A_STATUS);
        chk("exc_latch", 48'h1, {47'h0, rv[0]});
        chk("led_diag", 48'h1, {47'h0, ldiag});
        dreset();
        chk("alarm_held", 48'h1, {47'h0, alarm});
        @(posedge sys_clk);
        exc <= 16'hc8c8;
        ms(2);
        dreset();
        chk("alarm_clr", 48'h0, {47'h0, alarm});
    endtask
    // latched cable fault on ch0, test mode with fail, id words
    task automatic t_diag();
        wreg(A_LATCH0, 32'h1);
        cab <= 2'b10;
        ms(1);
        cab <= 2'b11;
        ms(1);
        #1;
        chk("diag_latched", 48'h1, {47'h0, alarm});
        dreset();
        chk("diag_clr", 48'h0, {47'h0, alarm});
        wreg(A_CTRL, 32'h1f);
        ms(10);
        rreg(A_DIAG1);
        chk("test_diag", 48'hff_ffbf, {16'h0, rv});
        chk("test_drive", 48'h3, {46'h0, tdrv});
        chk("leds", 48'h2, {46'h0, lfail, lrun});
        ms(300);
        rreg(A_ID0);
        chk("id0", 48'hffff_ffff, {16'h0, rv});
        rreg(A_ID1);
        chk("id1", 48'h0, {16'h0, rv});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_regs();
        t_frame();
        t_filter();
        t_event();
        t_exc();
        t_diag();
        tally_and_finish();
    end
    // watchdog well past the expected run
    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule
